// *** logic/dlvt_consts.svh ***
// Offsets, field positions, reset values and timing counts of the limit and threshold registers.
`ifndef DLVT_CONSTS_SVH
`define DLVT_CONSTS_SVH
`define DLVT_ADDR_CHARGE_OPTION_FOUR 8'h36
`define DLVT_ADDR_VMIN_PROTECT       8'h37
`define DLVT_LIM2_MSB                5
`define DLVT_LIM2_LSB                3
`define DLVT_LIM2_RESET              3'h1
`define DLVT_PROFILE_BIT             2
`define DLVT_TRIG_BIT                1
`define DLVT_PASS_BIT                0
`define DLVT_BUS_TH_MSB              15
`define DLVT_BUS_TH_LSB              9
`define DLVT_BUS_TH_RESET            7'h00
`define DLVT_RSVD_BIT                8
`define DLVT_SYS_TH_MSB              7
`define DLVT_SYS_TH_LSB              2
`define DLVT_SYS_TH_RESET_1S         6'h00
`define DLVT_SYS_TH_RESET_MULTI      6'h1b
`define DLVT_SYS_TH_1S_MAX           6'h07
`define DLVT_FOLLOW_BIT              1
`define DLVT_SWAP_BIT                0
`define DLVT_DEGLITCH_NS             5000
`define DLVT_CLK_PERIOD_NS           20
`define DLVT_DEGLITCH_CYC            ((`DLVT_DEGLITCH_NS + `DLVT_CLK_PERIOD_NS - 1) / `DLVT_CLK_PERIOD_NS)
`endif

// *** logic/dlvt_pkg.sv ***
// Types shared by the limit and threshold register block.
package dlvt_pkg;
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } dlvt_req_t;
    typedef struct packed {
        logic        rvalid;
        logic [15:0] rdata;
    } dlvt_rsp_t;
    typedef enum logic [1:0] {
        DLVT_SYS_OK   = 2'b01,
        DLVT_SYS_LOW  = 2'b10
    } dlvt_sys_state_t;
endpackage : dlvt_pkg

// *** logic/dlvt_regs.sv ***
// Second discharge limit and minimum-voltage protection registers with system-rail comparison.
//
// Contract
// - Second limit field bits 5:3, reset 001b.
// - Profile enable bit 2, read/write, reset 0.
// - Trigger flag bit 1 latched until read.
// - Bit 0 reports pass-through operation.
// - Bus threshold bits 15:9, 3.2V offset.
// - Bus threshold bits weigh 6400 down to 100mV.
// - Bus threshold resets to all zeros.
// - System status asserts when rail below threshold.
// - Comparison passes a 5 us deglitch filter.
// - System threshold 3.2V offset, 100mV steps.
// - Single cell caps threshold at code 000111b: xxx111b writes clamp, others above it are ignored.
// - System threshold reset depends on cell count.
// - Follow bit selects first system threshold instead.
// - Role swap forced low under high impedance.
`timescale 1ns/1ps
`default_nettype none
`include "dlvt_consts.svh"
module dlvt_regs (
    input  wire logic            sys_clk_in,
    input  wire logic            rst_in,
    input  wire dlvt_pkg::dlvt_req_t req_in,
    output var  dlvt_pkg::dlvt_rsp_t rsp_out,
    input  wire logic            single_cell_in,
    input  wire logic            limit_trigger_in,
    input  wire logic            passthrough_operation_in,
    input  wire logic            high_impedance_enable_in,
    input  wire logic [5:0]      first_system_threshold_in,
    input  wire logic [5:0]      system_rail_code_in,
    output logic [2:0]           second_discharge_limit_out,
    output logic                 second_limit_profile_enable_out,
    output logic [6:0]           input_bus_throttle_threshold_out,
    output logic [5:0]           system_rail_threshold_out,
    output logic                 role_swap_enable_out,
    output logic                 system_rail_status_out
);
    import dlvt_pkg::*;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Pins from the analogue side are asynchronous; codes are assumed to
    // be gray-stable while they move, so a plain two-stage capture serves.
    // A torn sample of the rail code lasts one cycle and cannot pass the deglitch count.
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic [5:0] rail_s1_reg;
    logic [5:0] rail_s2_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_reg   <= 4'h0;
            sync2_reg   <= 4'h0;
            rail_s1_reg <= 6'h3f;
            rail_s2_reg <= 6'h3f;
        end else begin
            sync1_reg   <= {single_cell_in, limit_trigger_in, passthrough_operation_in, high_impedance_enable_in};
            sync2_reg   <= sync1_reg;
            rail_s1_reg <= system_rail_code_in;
            rail_s2_reg <= rail_s1_reg;
        end
    end
    logic single_s;
    logic trig_s;
    logic pass_s;
    logic hiz_s;
    assign single_s = sync2_reg[3];
    assign trig_s   = sync2_reg[2];
    assign pass_s   = sync2_reg[1];
    assign hiz_s    = sync2_reg[0];

    // ------------------------------------------------------------------
    // Cell-count strap capture
    // ------------------------------------------------------------------
    // The cell-count reset value can only be applied after release, so the
    // threshold field is loaded once the synchronised strap has settled.
    logic [1:0] strap_cnt_reg;
    logic       strap_done_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            strap_cnt_reg  <= 2'h0;
            strap_done_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_cnt_reg  <= strap_cnt_reg + 2'h1;
            strap_done_reg <= (strap_cnt_reg == 2'h3);
        end
    end

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    logic wr_opt4;
    logic wr_vmin;
    logic rd_opt4;
    assign wr_opt4 = req_in.valid && req_in.write && (req_in.addr == `DLVT_ADDR_CHARGE_OPTION_FOUR);
    assign wr_vmin = req_in.valid && req_in.write && (req_in.addr == `DLVT_ADDR_VMIN_PROTECT);
    assign rd_opt4 = req_in.valid && !req_in.write && (req_in.addr == `DLVT_ADDR_CHARGE_OPTION_FOUR);

    logic [2:0] lim2_reg;
    logic       profile_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lim2_reg    <= `DLVT_LIM2_RESET;
            profile_reg <= 1'b0;
        end else if (wr_opt4) begin
            lim2_reg    <= req_in.wdata[`DLVT_LIM2_MSB:`DLVT_LIM2_LSB];
            profile_reg <= req_in.wdata[`DLVT_PROFILE_BIT];
        end
    end

    // Set beats clear: a trigger present during the read re-latches.
    // A read that meets a live trigger therefore leaves the flag set; it returns 1 only if the flag was already set before that edge.
    logic trig_flag_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            trig_flag_reg <= 1'b0;
        end else if (trig_s) begin
            trig_flag_reg <= 1'b1;
        end else if (rd_opt4) begin
            trig_flag_reg <= 1'b0;
        end
    end

    logic [6:0] bus_th_reg;
    logic       rsvd_reg;
    logic [5:0] sys_th_reg;
    logic       follow_reg;
    logic       swap_reg;
    logic [5:0] sys_th_wr;
    always_comb begin
        sys_th_wr = req_in.wdata[`DLVT_SYS_TH_MSB:`DLVT_SYS_TH_LSB];
        if (single_s && (sys_th_wr[2:0] == 3'h7)) begin
            sys_th_wr = `DLVT_SYS_TH_1S_MAX;
        end
    end
    logic sys_th_wr_ok;
    assign sys_th_wr_ok = !single_s || (sys_th_wr <= `DLVT_SYS_TH_1S_MAX);

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            bus_th_reg <= `DLVT_BUS_TH_RESET;
            rsvd_reg   <= 1'b0;
            sys_th_reg <= `DLVT_SYS_TH_RESET_1S;
            follow_reg <= 1'b0;
            swap_reg   <= 1'b0;
        end else if (!strap_done_reg) begin
            sys_th_reg <= single_s ? `DLVT_SYS_TH_RESET_1S : `DLVT_SYS_TH_RESET_MULTI;
        end else if (wr_vmin) begin
            bus_th_reg <= req_in.wdata[`DLVT_BUS_TH_MSB:`DLVT_BUS_TH_LSB];
            rsvd_reg   <= req_in.wdata[`DLVT_RSVD_BIT];
            if (sys_th_wr_ok) begin
                sys_th_reg <= sys_th_wr;
            end
            follow_reg <= req_in.wdata[`DLVT_FOLLOW_BIT];
            swap_reg   <= req_in.wdata[`DLVT_SWAP_BIT] && !hiz_s;
        end else if (hiz_s) begin
            swap_reg   <= 1'b0;
        end
    end

    // Read data is captured on the request edge, so the host sees the flag value from before
    // the clear that the same edge performs.
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rsp_out <= '0;
        end else begin
            rsp_out.rvalid <= req_in.valid && !req_in.write;
            if (req_in.valid && !req_in.write && req_in.addr == `DLVT_ADDR_CHARGE_OPTION_FOUR) begin
                rsp_out.rdata <= {10'h000, lim2_reg, profile_reg, trig_flag_reg, pass_s};
            end else if (req_in.valid && !req_in.write && req_in.addr == `DLVT_ADDR_VMIN_PROTECT) begin
                rsp_out.rdata <= {bus_th_reg, rsvd_reg, sys_th_reg, follow_reg, swap_reg};
            end else begin
                rsp_out.rdata <= 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // System-rail comparison with deglitch
    // ------------------------------------------------------------------
    // The effective threshold is the follow source or the programmed code;
    // the rail code uses the same 3.2V offset and 100mV step scale.
    // The counter restarts on any clean sample, so only an unbroken run of low samples counts.
    logic [5:0] eff_th;
    assign eff_th = follow_reg ? first_system_threshold_in : sys_th_reg;
    logic below;
    assign below = rail_s2_reg < eff_th;

    localparam int DEG_CYC = `DLVT_DEGLITCH_CYC;
    logic [8:0]      deg_cnt_reg;
    dlvt_sys_state_t sys_state_reg;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            deg_cnt_reg   <= 9'h000;
            sys_state_reg <= DLVT_SYS_OK;
        end else begin
            unique case (sys_state_reg)
                DLVT_SYS_OK: begin
                    if (!below) begin
                        deg_cnt_reg <= 9'h000;
                    end else if (deg_cnt_reg == 9'(DEG_CYC - 1)) begin
                        deg_cnt_reg   <= 9'h000;
                        sys_state_reg <= DLVT_SYS_LOW;
                    end else begin
                        deg_cnt_reg <= deg_cnt_reg + 9'h001;
                    end
                end
                DLVT_SYS_LOW: begin
                    if (!below) begin
                        sys_state_reg <= DLVT_SYS_OK;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            second_discharge_limit_out       <= `DLVT_LIM2_RESET;
            second_limit_profile_enable_out  <= 1'b0;
            input_bus_throttle_threshold_out <= `DLVT_BUS_TH_RESET;
            system_rail_threshold_out        <= `DLVT_SYS_TH_RESET_1S;
            role_swap_enable_out             <= 1'b0;
            system_rail_status_out           <= 1'b0;
        end else begin
            second_discharge_limit_out       <= lim2_reg;
            second_limit_profile_enable_out  <= profile_reg;
            input_bus_throttle_threshold_out <= bus_th_reg;
            system_rail_threshold_out        <= eff_th;
            role_swap_enable_out             <= swap_reg && !hiz_s;
            system_rail_status_out           <= (sys_state_reg == DLVT_SYS_LOW);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_flag_sets: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        trig_s |=> trig_flag_reg) else $error("trigger flag not set");
    a_flag_clears: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (rd_opt4 && !trig_s) |=> !trig_flag_reg) else $error("flag not cleared by read");
    a_flag_holds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (trig_flag_reg && !rd_opt4) |=> trig_flag_reg) else $error("flag dropped without read");
    a_swap_hiz: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        hiz_s |=> !role_swap_enable_out) else $error("swap on under high impedance");
    a_one_cell_clamp: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (strap_done_reg && single_s && $stable(single_s)) |-> sys_th_reg <= 6'h07)
        else $error("single cell threshold above clamp");
    a_lim2_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_opt4 |=> lim2_reg == $past(req_in.wdata[5:3])) else $error("limit write lost");
    a_bus_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_vmin && strap_done_reg) |=> bus_th_reg == $past(req_in.wdata[15:9]))
        else $error("bus threshold write lost");
    a_deglitch_min: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        $rose(sys_state_reg == DLVT_SYS_LOW) |-> $past(below, 250)) else $error("status before deglitch");
    a_status_out: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys_state_reg == DLVT_SYS_LOW) |=> system_rail_status_out) else $error("status not shown");
    a_profile_write: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_opt4 |=> profile_reg == $past(req_in.wdata[`DLVT_PROFILE_BIT]))
        else $error("profile write lost");
    a_limit_output: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        wr_opt4 |=> ##1 second_discharge_limit_out == $past(req_in.wdata[`DLVT_LIM2_MSB:`DLVT_LIM2_LSB], 2))
        else $error("limit output lags write");
    a_flag_read_value: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_opt4 |=> rsp_out.rdata[`DLVT_TRIG_BIT] == $past(trig_flag_reg))
        else $error("flag read value wrong");
    a_pass_report: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        rd_opt4 |=> rsp_out.rdata[`DLVT_PASS_BIT] == $past(pass_s))
        else $error("pass-through status wrong");
    a_strap_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !strap_done_reg |=> sys_th_reg == ($past(single_s) ? `DLVT_SYS_TH_RESET_1S : `DLVT_SYS_TH_RESET_MULTI))
        else $error("threshold reset value wrong");
    a_write_ignored: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (wr_vmin && strap_done_reg && !sys_th_wr_ok) |=> $stable(sys_th_reg))
        else $error("out of range threshold taken");
    a_follow_select: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        follow_reg |=> system_rail_threshold_out == $past(first_system_threshold_in))
        else $error("follow source not used");
    a_count_restart: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys_state_reg == DLVT_SYS_OK && !below) |=> deg_cnt_reg == 9'h000)
        else $error("deglitch count not restarted");
    a_status_release: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        (sys_state_reg == DLVT_SYS_LOW && !below) |=> sys_state_reg == DLVT_SYS_OK)
        else $error("status held after recovery");
    a_swap_forced: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        hiz_s |=> !swap_reg)
        else $error("swap bit kept under high impedance");

    // ------------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------------
    c_flag_read: cover property (@(posedge sys_clk_in) trig_flag_reg && rd_opt4);
    c_rail_low: cover property (@(posedge sys_clk_in) sys_state_reg == DLVT_SYS_LOW);
    c_follow: cover property (@(posedge sys_clk_in) follow_reg && below);
    c_write_ignored: cover property (@(posedge sys_clk_in) wr_vmin && strap_done_reg && !sys_th_wr_ok);
    c_swap_forced: cover property (@(posedge sys_clk_in) hiz_s && swap_reg);
endmodule : dlvt_regs
`default_nettype wire

// *** verif/dlvt_host_model.sv ***
// Host-side model that issues register requests to the limit and threshold block.
`timescale 1ns/1ps
`default_nettype none
module dlvt_host_model (
    input  wire logic                sys_clk_in,
    output var  dlvt_pkg::dlvt_req_t req_out,
    input  wire dlvt_pkg::dlvt_rsp_t rsp_in
);
    import dlvt_pkg::*;
    initial req_out = '0;
    // The host only writes whole words and passes any limit code, 000b to 111b, through as given.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        req_out <= '{valid: 1'b1, write: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk_in);
        req_out <= '0;
    endtask
    // The wait for the answer is bounded, so a silent block shows as a missing answer, not a hang.
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        req_out <= '{valid: 1'b1, write: 1'b0, addr: a, wdata: 16'h0000};
        @(posedge sys_clk_in);
        req_out <= '0;
        // The answer stands only in the cycle after the request edge, so it is looked at just after that edge.
        #1;
        while (rsp_in.rvalid !== 1'b1 && n < 4) begin
            @(posedge sys_clk_in);
            #1;
            n++;
        end
        ok = (rsp_in.rvalid === 1'b1);
        d = rsp_in.rdata;
    endtask
endmodule // dlvt_host_model
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench of the limit and threshold register block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dlvt_pkg::*;
    logic        sys_clk_in   = 1'b0;
    logic        rst_in       = 1'b1;
    logic        single_cell  = 1'b0;
    logic        trigger      = 1'b0;
    logic        passthru     = 1'b0;
    logic        hiz          = 1'b0;
    logic [5:0]  first_th     = 6'h05;
    logic [5:0]  rail_code    = 6'h3f;
    dlvt_req_t   req;
    dlvt_rsp_t   rsp;
    logic [2:0]  lim;
    logic        prof;
    logic        swap;
    logic        status;
    logic [6:0]  bus_th;
    logic [5:0]  sys_th;
    logic [15:0] rd_data;
    logic        got;
    int          failures     = 0;
    int          total_checks = 0;
    int          n;

    always #10 sys_clk_in = ~sys_clk_in;

    dlvt_regs dlvt_regs_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(req), .rsp_out(rsp),
        .single_cell_in(single_cell), .limit_trigger_in(trigger), .passthrough_operation_in(passthru),
        .high_impedance_enable_in(hiz), .first_system_threshold_in(first_th), .system_rail_code_in(rail_code),
        .second_discharge_limit_out(lim), .second_limit_profile_enable_out(prof),
        .input_bus_throttle_threshold_out(bus_th), .system_rail_threshold_out(sys_th),
        .role_swap_enable_out(swap), .system_rail_status_out(status));
    dlvt_host_model dlvt_host_model_i (.sys_clk_in(sys_clk_in), .req_out(req), .rsp_in(rsp));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [15:0] exp, input logic [15:0] act);
        total_checks++;
        if (act !== exp) begin
            failures++;
            $display("ERROR t=%0t exp=%h act=%h", $time, exp, act);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        dlvt_host_model_i.rd(a, rd_data, got);
        chk(16'h0001, {15'h0000, got});
        chk(exp, rd_data);
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic do_reset(input logic one_cell);
        @(posedge sys_clk_in);
        single_cell <= one_cell;
        rst_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
    endtask
    task automatic results;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        do_reset(1'b0);
        rdchk(8'h36, 16'h0008);
        rdchk(8'h37, 16'h006c);
        rdchk(8'h40, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            dlvt_host_model_i.wr(8'h36, {10'h3ff, c[2:0], 3'b111});
            rdchk(8'h36, {10'h000, c[2:0], 3'b100});
            chk({13'h0000, c[2:0]}, {13'h0000, lim});
            chk(16'h0001, {15'h0000, prof});
        end
        dlvt_host_model_i.wr(8'h36, 16'h0008);
        wt(2);
        chk(16'h0000, {15'h0000, prof});
        @(posedge sys_clk_in);
        trigger <= 1'b1;
        passthru <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        trigger <= 1'b0;
        wt(4);
        rdchk(8'h36, 16'h000b);
        rdchk(8'h36, 16'h0009);
        @(posedge sys_clk_in);
        trigger <= 1'b1;
        wt(4);
        rdchk(8'h36, 16'h000b);
        rdchk(8'h36, 16'h000b);
        @(posedge sys_clk_in);
        trigger <= 1'b0;
        passthru <= 1'b0;
        wt(4);
        rdchk(8'h36, 16'h000a);
        rdchk(8'h36, 16'h0008);
        for (int b = 0; b < 7; b++) begin
            dlvt_host_model_i.wr(8'h37, (16'h0200 << b) | 16'h006c);
            wt(2);
            chk({9'h000, 7'h01 << b}, {9'h000, bus_th});
        end
        dlvt_host_model_i.wr(8'h37, 16'hff6c);
        rdchk(8'h37, 16'hff6c);
        // A code one step under the threshold is the narrowest case the comparator must catch.
        @(posedge sys_clk_in);
        rail_code <= 6'h1a;
        wt(250);
        chk(16'h0000, {15'h0000, status});
        n = 0;
        while (status !== 1'b1 && n < 30) begin
            wt(1);
            n++;
        end
        chk(16'h0001, {15'h0000, status});
        @(posedge sys_clk_in);
        rail_code <= 6'h1b;
        n = 0;
        while (status !== 1'b0 && n < 300) begin
            wt(1);
            n++;
        end
        chk(16'h0000, {15'h0000, status});
        dlvt_host_model_i.wr(8'h37, 16'h006e);
        wt(2);
        chk(16'h0005, {10'h000, sys_th});
        dlvt_host_model_i.wr(8'h37, 16'h006c);
        wt(2);
        chk(16'h001b, {10'h000, sys_th});
        @(posedge sys_clk_in);
        hiz <= 1'b1;
        dlvt_host_model_i.wr(8'h37, 16'h006d);
        wt(4);
        chk(16'h0000, {15'h0000, swap});
        @(posedge sys_clk_in);
        hiz <= 1'b0;
        wt(4);
        chk(16'h0000, {15'h0000, swap});
        dlvt_host_model_i.wr(8'h37, 16'h006d);
        wt(2);
        chk(16'h0001, {15'h0000, swap});
        do_reset(1'b1);
        rdchk(8'h37, 16'h0000);
        dlvt_host_model_i.wr(8'h37, 16'h00fc);
        rdchk(8'h37, 16'h001c);
        dlvt_host_model_i.wr(8'h37, 16'h0024);
        wt(2);
        chk(16'h0007, {10'h000, sys_th});
        dlvt_host_model_i.wr(8'h37, 16'h000c);
        wt(2);
        chk(16'h0003, {10'h000, sys_th});
        results();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        failures++;
        results();
    end
endmodule // tb_top
`default_nettype wire
